// ===== hdl/printer_port.sv
/*
 * Bidirectional printer port: data, status and control registers on a
 * classic Wishbone slave, the printer connector pins, and an interrupt.
 * Assumes printer inputs and the mode pin are asynchronous to mclk; the
 * connector's data and interrupt wires are resolved from the enables outside.
 */
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

module printer_port
(
   input  wire  logic                          mclk,
   input  wire  logic                          rstn,
   input  wire  logic                          wb_cyc_i,
   input  wire  logic                          wb_stb_i,
   input  wire  logic                          wb_we_i,
   input  wire  logic [3:0]                    wb_sel_i,
   input  wire  logic [31:0]                   wb_adr_i,
   input  wire  logic [31:0]                   wb_dat_i,
   output var   logic [31:0]                   wb_dat_o,
   output var   logic                          wb_ack_o,
   input  wire  logic                          enhancement_mode_pin,
   input  wire  logic [7:0]                    printer_data_lines_i,
   output var   logic [7:0]                    printer_data_lines_o,
   output var   logic                          printer_data_lines_oe,
   input  wire  printer_port_pkg::printer_in_t printer_in,
   output var   printer_port_pkg::printer_ctl_t printer_ctl,
   output var   logic                          printer_irq_line_o,
   output var   logic                          printer_irq_line_oe,
   output var   logic                          irq
);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   // The mode pin and every connector input are asynchronous to mclk, so each
   // passes two flip-flops before any logic looks at it. Only the second stage
   // is ever read.
   logic mode_sync1;
   logic mode_sync2;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_sync1 <= 1'b0;
         mode_sync2 <= 1'b0;
      end
      else
      begin
         mode_sync1 <= enhancement_mode_pin;
         mode_sync2 <= mode_sync1;
      end
   end

   // The data lines are sampled bit by bit; a byte read while the far side
   // changes them can mix old and new bits, so software should read twice.
   logic [7:0] data_sync1;
   logic [7:0] data_sync2;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         data_sync1 <= 8'h00;
         data_sync2 <= 8'h00;
      end
      else
      begin
         data_sync1 <= printer_data_lines_i;
         data_sync2 <= data_sync1;
      end
   end

   // The status pins reset to their idle levels, so that the acknowledge
   // edge detector sees no false trailing edge while the stages fill.
   printer_port_pkg::printer_in_t pins_sync1;
   printer_port_pkg::printer_in_t pins_sync2;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pins_sync1 <= printer_port_pkg::pins_idle;
         pins_sync2 <= printer_port_pkg::pins_idle;
      end
      else
      begin
         pins_sync1 <= printer_in;
         pins_sync2 <= pins_sync1;
      end
   end

   logic                          mode_enh;
   logic [7:0]                    pins_data;
   printer_port_pkg::printer_in_t pins;
   assign mode_enh  = mode_sync2;
   assign pins_data = data_sync2;
   assign pins      = pins_sync2;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   // Only byte lane 0 carries a register; a write with sel[0] low is
   // acknowledged and dropped, so a wide master never stalls here.
   logic [29:0] word_idx;
   logic        req;
   logic        wr_lane0;
   logic        rd_take;
   logic        hit_data;
   logic        hit_status;
   logic        hit_control;
   logic        hit_irq_st;
   logic        hit_irq_msk;
   assign word_idx    = wb_adr_i[31:printer_port_pkg::addr_lsb];
   assign req         = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lane0    = req & wb_we_i & wb_sel_i[0];
   assign rd_take     = req & ~wb_we_i;
   assign hit_data    = word_idx == 30'(printer_port_pkg::idx_data);
   assign hit_status  = word_idx == 30'(printer_port_pkg::idx_status);
   assign hit_control = word_idx == 30'(printer_port_pkg::idx_control);
   assign hit_irq_st  = word_idx == 30'(printer_port_pkg::idx_irq_st);
   assign hit_irq_msk = word_idx == 30'(printer_port_pkg::idx_irq_msk);

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] data_out;
   logic [7:0] control;
   logic       dir_input;
   assign dir_input = mode_enh & control[printer_port_pkg::ctl_dir];

   // Writes latch in every mode; only the driver and the readback depend on direction.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         data_out <= printer_port_pkg::data_reset;
      else if (wr_lane0 && hit_data)
         data_out <= wb_dat_i[7:0];
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         control <= printer_port_pkg::control_reset;
      else if (wr_lane0 && hit_control)
         control <= wb_dat_i[7:0] & printer_port_pkg::ctl_writable;
   end

   // -----------------------------------------------------------------
   // Acknowledge pending flag (active low when stored)
   // -----------------------------------------------------------------
   logic ack_prev;
   logic ack_fall;
   logic pending_n;
   logic status_read;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ack_prev <= 1'b1;
      else
         ack_prev <= pins.ack;
   end
   // The acknowledge input is active low; the trailing edge is a rise.
   assign ack_fall    = pins.ack & ~ack_prev;
   assign status_read = rd_take & hit_status;

   // A trailing edge in the cycle of a status read wins, so no event is lost.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         pending_n <= 1'b1;
      else if (ack_fall && control[printer_port_pkg::ctl_irq_en])
         pending_n <= 1'b0;
      else if (status_read)
         pending_n <= 1'b1;
   end

   // -----------------------------------------------------------------
   // Sticky interrupt status and mask
   // -----------------------------------------------------------------
   // The sticky bit keeps an acknowledge visible to the mask and the level
   // interrupt even after a status read has re-armed the pending flag.
   logic irq_st;
   logic irq_msk;
   logic irq_event;
   assign irq_event = ack_fall & control[printer_port_pkg::ctl_irq_en];

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         irq_st <= printer_port_pkg::irq_st_reset;
      else if (irq_event)
         irq_st <= 1'b1;
      else if (rd_take && hit_irq_st)
         irq_st <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         irq_msk <= printer_port_pkg::irq_msk_reset;
      else if (wr_lane0 && hit_irq_msk)
         irq_msk <= wb_dat_i[0];
   end

   // -----------------------------------------------------------------
   // Read mux and acknowledge
   // -----------------------------------------------------------------
   logic [7:0] status_val;
   logic [7:0] data_val;
   logic [7:0] next_rd;
   assign status_val = {pins.occupied, pins.ack, pins.paper_out, pins.selected,
                        pins.fault, pending_n, printer_port_pkg::status_reserved};
   assign data_val   = dir_input ? pins_data : data_out;

   always_comb
   begin
      next_rd = 8'h00;
      if (hit_data)
         next_rd = data_val;
      else if (hit_status)
         next_rd = status_val;
      else if (hit_control)
         next_rd = control;
      else if (hit_irq_st)
         next_rd = {7'h00, irq_st};
      else if (hit_irq_msk)
         next_rd = {7'h00, irq_msk};
   end

   // Unmapped addresses are acknowledged and read zero, so no master hangs.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req;
   end

   // Read data holds until the next read is taken, so a master that samples
   // it late still sees the value it asked for.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         wb_dat_o <= 32'h0000_0000;
      else if (rd_take)
         wb_dat_o <= {24'h00_0000, next_rd};
   end

   // -----------------------------------------------------------------
   // Connector outputs
   // -----------------------------------------------------------------
   // Each connector output has its own register, so every pin follows the
   // register bit behind it one mclk edge later and never glitches.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         printer_data_lines_o <= 8'h00;
      else
         printer_data_lines_o <= data_out;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         printer_data_lines_oe <= 1'b0;
      else
         printer_data_lines_oe <= ~dir_input;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         printer_ctl <= 4'h0;
      else
      begin
         printer_ctl.strobe    <= control[printer_port_pkg::ctl_strobe];
         printer_ctl.linefeed  <= control[printer_port_pkg::ctl_linefeed];
         printer_ctl.select_in <= control[printer_port_pkg::ctl_select_in];
         printer_ctl.init      <= ~control[printer_port_pkg::ctl_init];
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         printer_irq_line_o <= 1'b0;
      else
         printer_irq_line_o <= ~pending_n;
   end

   // The line itself floats while interrupts are disabled; the pad outside
   // resolves it from this enable.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         printer_irq_line_oe <= 1'b0;
      else
         printer_irq_line_oe <= control[printer_port_pkg::ctl_irq_en];
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else
         irq <= irq_st & irq_msk;
   end

endmodule // printer_port

`default_nettype wire

// ===== hdl/printer_port_pkg.sv
/*
 * Constants and carrier types for the bidirectional printer port.
 * Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
 */
package printer_port_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [1:0] idx_data    = 2'h0;
   localparam logic [1:0] idx_status  = 2'h1;
   localparam logic [1:0] idx_control = 2'h2;
   localparam logic [1:0] idx_irq_st  = 2'h3;
   localparam logic [2:0] idx_irq_msk = 3'h4;
   localparam int         addr_lsb    = 2;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int ctl_strobe    = 0;
   localparam int ctl_linefeed  = 1;
   localparam int ctl_init      = 2;
   localparam int ctl_select_in = 3;
   localparam int ctl_irq_en    = 4;
   localparam int ctl_dir       = 5;
   localparam logic [7:0] ctl_writable = 8'h3f;

   localparam logic [1:0] status_reserved = 2'h3;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] data_reset    = 8'h00;
   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [0:0] irq_st_reset  = 1'h0;
   localparam logic [0:0] irq_msk_reset = 1'h0;

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic fault;
      logic selected;
      logic paper_out;
      logic ack;
      logic occupied;
   } printer_in_t;

   // Idle connector levels: every status input low except the active-low acknowledge.
   localparam printer_in_t pins_idle = 5'h02;

   typedef struct packed {
      logic strobe;
      logic linefeed;
      logic init;
      logic select_in;
   } printer_ctl_t;

endpackage

// ===== bench/printer_port_assertions.sv
/* Checker for the printer port's bus timing, pin outputs and readback.
   Assumes it is bound to printer_port and sees only that module's ports. */
`timescale 1ns/100ps
`default_nettype none
module printer_port_assertions
(
   input wire logic                           mclk,
   input wire logic                           rstn,
   input wire logic                           wb_cyc_i,
   input wire logic                           wb_stb_i,
   input wire logic                           wb_we_i,
   input wire logic [3:0]                     wb_sel_i,
   input wire logic [31:0]                    wb_adr_i,
   input wire logic [31:0]                    wb_dat_i,
   input wire logic [31:0]                    wb_dat_o,
   input wire logic                           wb_ack_o,
   input wire logic [7:0]                     printer_data_lines_o,
   input wire printer_port_pkg::printer_ctl_t printer_ctl,
   input wire logic                           printer_irq_line_o,
   input wire logic                           printer_irq_line_oe
);
   logic       tk, wr, rd;
   logic [2:0] ix;
   logic [7:0] sh, p, dsh, q;
   assign ix = wb_adr_i[4:2];
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = tk && wb_we_i && wb_sel_i[0];
   assign rd = tk && !wb_we_i;
   // The second shadow stage matches the one register between a write and the pins.
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         sh  <= printer_port_pkg::control_reset;
         p   <= printer_port_pkg::control_reset;
         dsh <= printer_port_pkg::data_reset;
         q   <= printer_port_pkg::data_reset;
      end
      else
      begin
         sh  <= (wr && ix == 3'h2) ? wb_dat_i[7:0] : sh;
         dsh <= (wr && ix == 3'h0) ? wb_dat_i[7:0] : dsh;
         p   <= sh;
         q   <= dsh;
      end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   a_ack_follows: assert property (tk |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   a_unmapped_zero: assert property (rd && ix > 3'h4 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_ctl_pins: assert property ($past(rstn) |-> printer_ctl == {p[0], p[1], ~p[2], p[3]})
      else $error("control pins differ from control register");
   a_irq_float: assert property ($past(rstn) |-> printer_irq_line_oe == p[4])
      else $error("interrupt line enable differs from control bit 4");
   a_data_pins: assert property ($past(rstn) |-> printer_data_lines_o == q)
      else $error("data lines differ from last written data");
   a_status_ones: assert property (rd && ix == 3'h1 |=> wb_dat_o[1:0] == 2'h3)
      else $error("status bits 0 and 1 not one");
   a_ctl_readback: assert property (rd && ix == 3'h2 |=> wb_dat_o == {26'h0, sh[5:0]})
      else $error("control readback wrong");
   a_pending_rearm: assert property (rd && ix == 3'h1 |-> ##2 !printer_irq_line_o)
      else $error("status read did not withdraw pending indication");
endmodule // printer_port_assertions
bind printer_port printer_port_assertions chk
(
   .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .printer_data_lines_o(printer_data_lines_o),
   .printer_ctl(printer_ctl), .printer_irq_line_o(printer_irq_line_o),
   .printer_irq_line_oe(printer_irq_line_oe)
);
`default_nettype wire

// ===== bench/printer_model.sv
/* Printer on the connector: answers each strobe that rises while it is idle with an acknowledge pulse.
   Assumes the bench sets the status flags, the answer delay and any data it drives. */
`timescale 1ns/100ps
`default_nettype none
module printer_model
(
   input wire logic                          mclk,
   input wire logic                          rstn,
   input wire logic                          strobe,
   input wire logic [7:0]                    host_o,
   input wire logic                          host_oe,
   input wire logic [7:0]                    dev_val,
   input wire logic                          dev_oe,
   input wire logic [3:0]                    flags,
   input wire logic [3:0]                    delay,
   output var printer_port_pkg::printer_in_t pins,
   output var logic [7:0]                    lines
);
   logic       s_q, ack_n;
   logic [4:0] cnt;
   // An undriven bus shows the inverse of the host's value, never a kind copy.
   assign lines = host_oe ? host_o : (dev_oe ? dev_val : ~host_o);
   assign ack_n = !(cnt != 5'h0 && cnt <= 5'h4);
   assign pins = {flags[3], flags[2], flags[1], ack_n, flags[0] | (cnt != 5'h0)};
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         s_q <= 1'b0;
         cnt <= 5'h0;
      end
      else
      begin
         s_q <= strobe;
         cnt <= (strobe && !s_q && cnt == 5'h0) ? {1'b0, delay} + 5'h5 :
                (cnt != 5'h0) ? cnt - 5'h1 : cnt;
      end
endmodule // printer_model
`default_nettype wire

// ===== bench/printer_port_tb.sv
/* Self-checking bench for the printer port.
   Assumes the checker is bound in and the printer model stands on the connector. */
`timescale 1ns/100ps
`default_nettype none
module printer_port_tb;
   logic        mclk, rstn, cyc, stb, we, mode, ack, d_oe, irq_o, irq_oe, irq, dev_oe;
   logic [31:0] adr, dat, dat_o;
   logic [7:0]  rd, d_o, lines, dev_val;
   logic [3:0]  flags, delay;
   int          n_errors, check_count, cycles;
   printer_port_pkg::printer_in_t  pins;
   printer_port_pkg::printer_ctl_t ctl;
   printer_port DUT (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .enhancement_mode_pin(mode), .printer_data_lines_i(lines), .printer_data_lines_o(d_o),
      .printer_data_lines_oe(d_oe), .printer_in(pins), .printer_ctl(ctl),
      .printer_irq_line_o(irq_o), .printer_irq_line_oe(irq_oe), .irq(irq));
   printer_model partner (.mclk(mclk), .rstn(rstn), .strobe(ctl.strobe), .host_o(d_o),
      .host_oe(d_oe), .dev_val(dev_val), .dev_oe(dev_oe), .flags(flags), .delay(delay),
      .pins(pins), .lines(lines));
   always #5 mclk = ~mclk;
   task automatic wb(input logic w, input logic [2:0] ix, input logic [7:0] wd);
      int n;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {27'h0, ix, 2'h0};
      dat <= {24'h0, wd};
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      rd = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) n_errors++;
   endtask
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic t_reset;
      // Status pins need two edges through the synchroniser after reset.
      repeat (2) @(posedge mclk);
      wb(0, 1, 0); check("status", 8'h6f, rd);
      flags <= 4'b0101;
      repeat (4) @(posedge mclk);
      wb(0, 1, 0); check("status", 8'hd7, rd);
      wb(0, 2, 0); check("control", 8'h00, rd);
      wb(0, 7, 0); check("unmapped", 8'h00, rd);
      $display("t_reset done");
   endtask
   task automatic t_control;
      logic [7:0] v [4] = '{8'hff, 8'h2a, 8'h15, 8'h00};
      foreach (v[i])
      begin
         wb(1, 2, v[i]);
         wb(0, 2, 0); check("control", v[i] & 8'h3f, rd);
         check("pins", {4'h0, v[i][0], v[i][1], ~v[i][2], v[i][3]}, {4'h0, ctl});
         check("irq_oe", {7'h0, v[i][4]}, {7'h0, irq_oe});
         check("data_oe", 8'h01, {7'h0, d_oe});
      end
      $display("t_control done");
   endtask
   task automatic t_data;
      wb(1, 0, 8'ha5); wb(0, 0, 0); check("data", 8'ha5, rd);
      check("lines", 8'ha5, lines);
      mode <= 1'b1;
      wb(1, 2, 8'h24);
      dev_val <= 8'h3c;
      dev_oe <= 1'b1;
      repeat (4) @(posedge mclk);
      check("data_oe", 8'h00, {7'h0, d_oe});
      wb(0, 0, 0); check("data", 8'h3c, rd);
      wb(1, 0, 8'h5a); wb(0, 0, 0); check("data", 8'h3c, rd);
      dev_oe <= 1'b0;
      wb(1, 2, 8'h04); wb(0, 0, 0); check("data", 8'h5a, rd);
      check("lines", 8'h5a, lines);
      mode <= 1'b0;
      $display("t_data done");
   endtask
   task automatic t_irq;
      int n;
      wb(1, 4, 8'h01); wb(1, 2, 8'h14); wb(0, 1, 0); wb(0, 3, 0);
      check("irq", 8'h00, {7'h0, irq});
      delay <= 4'h9;
      wb(1, 2, 8'h15);
      for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge mclk);
      repeat (2) @(posedge mclk);
      check("irq", 8'h01, {7'h0, irq});
      check("irq_line", 8'h01, {7'h0, irq_o});
      wb(0, 1, 0); check("pending", 8'h00, rd & 8'h04);
      wb(0, 1, 0); check("pending", 8'h04, rd & 8'h04);
      check("irq_line", 8'h00, {7'h0, irq_o});
      wb(0, 3, 0); check("irq_status", 8'h01, rd);
      wb(0, 3, 0); check("irq_status", 8'h00, rd);
      wb(1, 2, 8'h04); wb(1, 2, 8'h05);
      repeat (40) @(posedge mclk);
      wb(0, 1, 0); check("pending", 8'h04, rd & 8'h04);
      check("irq", 8'h00, {7'h0, irq});
      $display("t_irq done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         final_report;
      end
   end
   initial
   begin
      {mclk, rstn, cyc, stb, we, mode, dev_oe} = '0;
      {adr, dat, dev_val, delay} = '0;
      flags = 4'b1010;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_control;
      t_data;
      t_irq;
      final_report;
   end
endmodule // printer_port_tb
`default_nettype wire
